/* common/cex_regs.svh */
// Register offsets, field positions, event codes and vector constants of the exception unit
`ifndef CEX_REGS_SVH
`define CEX_REGS_SVH
// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define CEX_ADDR_TRAP_IMM    32'h0FFF_FFD0
`define CEX_ADDR_EXC_CODE    32'h0FFF_FFD4
`define CEX_ADDR_INT_CODE    32'h0FFF_FFD8
`define CEX_ADDR_INT_ALT     32'h0400_0000
`define CEX_ADDR_VEC_BASE    32'h0FFF_FFC0
`define CEX_ADDR_STATUS      32'h0FFF_FFC4
`define CEX_ADDR_SAVED_PC    32'h0FFF_FFC8
`define CEX_ADDR_SAVED_SR    32'h0FFF_FFCC
// ----------------------------------------------------------------------------
// Status word fields and reset values
// ----------------------------------------------------------------------------
`define CEX_SR_PRIV          30
`define CEX_SR_BANK          29
`define CEX_SR_BLOCK         28
`define CEX_SR_RESET         32'h7000_00F0
`define CEX_ZERO32           32'h0000_0000
// ----------------------------------------------------------------------------
// Vectors and offsets
// ----------------------------------------------------------------------------
`define CEX_RESET_VECTOR     32'hA000_0000
`define CEX_OFS_TLB_MISS     32'h0000_0400
`define CEX_OFS_GENERAL      32'h0000_0100
`define CEX_OFS_INTERRUPT    32'h0000_0600
// ----------------------------------------------------------------------------
// Event codes (bits 11 down to 0)
// ----------------------------------------------------------------------------
`define CEX_CODE_POWER_ON    12'h000
`define CEX_CODE_MANUAL      12'h020
`define CEX_CODE_TLB_RD      12'h040
`define CEX_CODE_TLB_WR      12'h060
`define CEX_CODE_INIT_WRITE  12'h080
`define CEX_CODE_PROT_RD     12'h0A0
`define CEX_CODE_PROT_WR     12'h0C0
`define CEX_CODE_ADDR_RD     12'h0E0
`define CEX_CODE_ADDR_WR     12'h100
`define CEX_CODE_TRAP        12'h160
`define CEX_CODE_RSV_INSTR   12'h180
`define CEX_CODE_ILL_SLOT    12'h1A0
`define CEX_CODE_NMI         12'h1C0
`define CEX_CODE_W           12
`endif

/* common/cex_pkg.sv */
// Types shared by the exception entry unit
package cex_pkg;
  // General exception requests from the pipeline, one bit per event
  typedef struct packed {
    logic fetch_addr_err;
    logic fetch_tlb_miss;
    logic fetch_tlb_inv;
    logic fetch_prot;
    logic rsv_instr;
    logic ill_slot;
    logic trap;
    logic data_addr_err;
    logic data_tlb_miss;
    logic data_tlb_inv;
    logic data_prot;
    logic init_write;
  } cex_gexc_t;
  // Outcome of the acceptance order
  typedef struct packed {
    logic        hit;
    logic        tlb_vec;
    logic [11:0] code;
  } cex_sel_t;
  // Fetch redirect towards the pipeline
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } cex_redir_t;
endpackage

/* core/cex_entry.sv */
// Exception entry, vector selection, return and event registers with an APB slave
`timescale 1ns/1ps
`include "cex_regs.svh"
module cex_entry
  import cex_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             manual_reset_n,
  input  wire logic [31:0]      cur_pc,
  input  wire cex_gexc_t        gexc_req,
  input  wire logic             data_write,
  input  wire logic [7:0]       trap_imm,
  input  wire logic             instr_done,
  input  wire logic             nmi_req,
  input  wire logic             irq_req,
  input  wire logic [11:0]      irq_code,
  input  wire logic             rte_exec,
  output cex_redir_t            redirect,
  output logic                  irq_ack,
  output logic      [31:0]      status_word
);
  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // Acceptance order among general exceptions of one instruction
  function automatic cex_sel_t order_pick(input cex_gexc_t r, input logic wr);
    cex_sel_t s;
    s = '{hit: 1'b1, tlb_vec: 1'b0, code: `CEX_CODE_ADDR_RD};
    if (r.fetch_addr_err) begin
      s.code = `CEX_CODE_ADDR_RD;
    end else if (r.fetch_tlb_miss) begin
      s.code    = `CEX_CODE_TLB_RD;
      s.tlb_vec = 1'b1;
    end else if (r.fetch_tlb_inv) begin
      s.code = `CEX_CODE_TLB_RD;
    end else if (r.fetch_prot) begin
      s.code = `CEX_CODE_PROT_RD;
    end else if (r.rsv_instr) begin
      s.code = `CEX_CODE_RSV_INSTR;
    end else if (r.ill_slot) begin
      s.code = `CEX_CODE_ILL_SLOT;
    end else if (r.trap) begin
      s.code = `CEX_CODE_TRAP;
    end else if (r.data_addr_err) begin
      s.code = wr ? `CEX_CODE_ADDR_WR : `CEX_CODE_ADDR_RD;
    end else if (r.data_tlb_miss) begin
      s.code    = wr ? `CEX_CODE_TLB_WR : `CEX_CODE_TLB_RD;
      s.tlb_vec = 1'b1;
    end else if (r.data_tlb_inv) begin
      s.code = wr ? `CEX_CODE_TLB_WR : `CEX_CODE_TLB_RD;
    end else if (r.data_prot) begin
      s.code = wr ? `CEX_CODE_PROT_WR : `CEX_CODE_PROT_RD;
    end else if (r.init_write) begin
      s.code = `CEX_CODE_INIT_WRITE;
    end else begin
      s.hit = 1'b0;
    end
    return s;
  endfunction

  // Handler address: wrapping 32-bit sum of base and offset
  function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [31:0] ofs);
    logic [32:0] sum;
    sum = {1'b0, base} + {1'b0, ofs};
    return sum[31:0];
  endfunction

  // Byte-lane merge of an APB write
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [31:0] trap_immediate_r;
  logic [31:0] exception_event_code_r;
  logic [31:0] interrupt_event_code_r;
  logic [31:0] interrupt_event_code_alt_r;
  logic [31:0] vector_base_r;
  logic [31:0] status_word_r;
  logic [31:0] saved_program_counter_r;
  logic [31:0] saved_status_word_r;
  logic        mrst_s1_r;
  logic        mrst_s2_r;
  logic        mrst_s3_r;
  logic        por_pend_r;
  cex_redir_t  redirect_r;
  logic        irq_ack_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  // --------------------------------------------------------------------------
  // Event classification and selection
  // --------------------------------------------------------------------------
  cex_sel_t    gsel;
  logic        block_bit;
  logic        mrst_take;
  logic        reset_take;
  logic        gexc_take;
  logic        gexc_enter;
  logic        blocked_fault;
  logic        irq_take;
  logic        rte_take;
  logic        entry;
  logic [11:0] int_code;
  logic [31:0] entry_sr;

  // Manual reset edge after the synchroniser, power-on redirect once
  assign gsel          = order_pick(gexc_req, data_write);
  assign block_bit     = status_word_r[`CEX_SR_BLOCK];
  assign mrst_take     = ~mrst_s2_r & mrst_s3_r;
  assign reset_take    = mrst_take | por_pend_r;
  // Resets first, general exceptions second, interrupts third, return last
  assign gexc_take     = gsel.hit & ~reset_take;
  assign gexc_enter    = gexc_take & ~block_bit;
  assign blocked_fault = gexc_take & block_bit;
  assign irq_take      = (nmi_req | irq_req) & instr_done & ~block_bit
                         & ~reset_take & ~gsel.hit;
  assign rte_take      = rte_exec & ~reset_take & ~gsel.hit & ~irq_take;
  assign entry         = gexc_enter | irq_take;
  assign int_code      = nmi_req ? `CEX_CODE_NMI : irq_code;
  // Status on entry: block, privilege and bank all set
  assign entry_sr      = status_word_r | (32'h0000_0001 << `CEX_SR_BLOCK)
                                       | (32'h0000_0001 << `CEX_SR_PRIV)
                                       | (32'h0000_0001 << `CEX_SR_BANK);

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  logic        apb_setup;
  logic        apb_wr;
  logic        hit_trap;
  logic        hit_exc;
  logic        hit_int;
  logic        hit_alt;
  logic        hit_vb;
  logic        hit_sr;
  logic        hit_spc;
  logic        hit_ssr;
  logic        hit_any;
  logic [31:0] rd_mux;

  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign hit_trap  = paddr == `CEX_ADDR_TRAP_IMM;
  assign hit_exc   = paddr == `CEX_ADDR_EXC_CODE;
  assign hit_int   = paddr == `CEX_ADDR_INT_CODE;
  assign hit_alt   = paddr == `CEX_ADDR_INT_ALT;
  assign hit_vb    = paddr == `CEX_ADDR_VEC_BASE;
  assign hit_sr    = paddr == `CEX_ADDR_STATUS;
  assign hit_spc   = paddr == `CEX_ADDR_SAVED_PC;
  assign hit_ssr   = paddr == `CEX_ADDR_SAVED_SR;
  assign hit_any   = hit_trap | hit_exc | hit_int | hit_alt | hit_vb | hit_sr | hit_spc | hit_ssr;
  assign rd_mux    = hit_trap ? trap_immediate_r :
                     hit_exc  ? exception_event_code_r :
                     hit_int  ? interrupt_event_code_r :
                     hit_alt  ? interrupt_event_code_alt_r :
                     hit_vb   ? vector_base_r :
                     hit_sr   ? status_word_r :
                     hit_spc  ? saved_program_counter_r :
                     hit_ssr  ? saved_status_word_r : `CEX_ZERO32;

  // --------------------------------------------------------------------------
  // Next values; hardware events win over a same-cycle software write
  // --------------------------------------------------------------------------
  logic [31:0] status_word_nxt;
  logic [31:0] exc_code_nxt;
  logic [31:0] int_code_nxt;
  logic [31:0] trap_nxt;
  logic [31:0] redirect_addr_nxt;

  assign status_word_nxt   = (reset_take | blocked_fault) ? `CEX_SR_RESET :
                             entry     ? entry_sr :
                             rte_take  ? saved_status_word_r :
                             (apb_wr & hit_sr) ? lane_merge(status_word_r, pwdata, pstrb) :
                             status_word_r;
  assign exc_code_nxt      = mrst_take  ? {20'h0_0000, `CEX_CODE_MANUAL} :
                             por_pend_r ? {20'h0_0000, `CEX_CODE_POWER_ON} :
                             gexc_take  ? {20'h0_0000, gsel.code} :
                             (apb_wr & hit_exc) ? lane_merge(exception_event_code_r, pwdata, pstrb) :
                             exception_event_code_r;
  assign int_code_nxt      = irq_take ? {20'h0_0000, int_code} :
                             (apb_wr & hit_int) ? lane_merge(interrupt_event_code_r, pwdata, pstrb) :
                             interrupt_event_code_r;
  assign trap_nxt          = (gexc_enter & gsel.code == `CEX_CODE_TRAP) ? {24'h00_0000, trap_imm} :
                             (apb_wr & hit_trap) ? lane_merge(trap_immediate_r, pwdata, pstrb) :
                             trap_immediate_r;
  assign redirect_addr_nxt = (reset_take | blocked_fault) ? `CEX_RESET_VECTOR :
                             gexc_enter ? vec_addr(vector_base_r, gsel.tlb_vec ?
                                                   `CEX_OFS_TLB_MISS : `CEX_OFS_GENERAL) :
                             irq_take   ? vec_addr(vector_base_r, `CEX_OFS_INTERRUPT) :
                             saved_program_counter_r;

  // --------------------------------------------------------------------------
  // Manual reset synchroniser
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mrst_s1_r <= 1'b1;
      mrst_s2_r <= 1'b1;
      mrst_s3_r <= 1'b1;
    end else begin
      mrst_s1_r <= manual_reset_n;
      mrst_s2_r <= mrst_s1_r;
      mrst_s3_r <= mrst_s2_r;
    end
  end

  // Event code, status and trap registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_word_r              <= `CEX_SR_RESET;
      exception_event_code_r     <= `CEX_ZERO32;
      interrupt_event_code_r     <= `CEX_ZERO32;
      interrupt_event_code_alt_r <= `CEX_ZERO32;
      trap_immediate_r           <= `CEX_ZERO32;
      por_pend_r                 <= 1'b1;
    end else begin
      status_word_r              <= status_word_nxt;
      exception_event_code_r     <= exc_code_nxt;
      interrupt_event_code_r     <= int_code_nxt;
      interrupt_event_code_alt_r <= irq_take ? {20'h0_0000, int_code} : interrupt_event_code_alt_r;
      trap_immediate_r           <= trap_nxt;
      por_pend_r                 <= 1'b0;
    end
  end

  // Saved copies and vector base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_program_counter_r <= `CEX_ZERO32;
      saved_status_word_r     <= `CEX_ZERO32;
      vector_base_r           <= `CEX_ZERO32;
    end else begin
      if (entry) begin
        saved_program_counter_r <= cur_pc;
        saved_status_word_r     <= status_word_r;
      end else if (apb_wr & hit_spc) begin
        saved_program_counter_r <= lane_merge(saved_program_counter_r, pwdata, pstrb);
      end else if (apb_wr & hit_ssr) begin
        saved_status_word_r     <= lane_merge(saved_status_word_r, pwdata, pstrb);
      end
      if (apb_wr & hit_vb) begin
        vector_base_r <= lane_merge(vector_base_r, pwdata, pstrb);
      end
    end
  end

  // Redirect and acknowledge towards the pipeline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      redirect_r <= '{valid: 1'b0, addr: `CEX_RESET_VECTOR};
      irq_ack_r  <= 1'b0;
    end else begin
      redirect_r.valid <= reset_take | gexc_take | irq_take | rte_take;
      redirect_r.addr  <= redirect_addr_nxt;
      irq_ack_r        <= irq_take;
    end
  end

  // APB answer: prepared in setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= `CEX_ZERO32;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup & (~hit_any | (pwrite & hit_alt));
      prdata_r  <= (apb_setup & ~pwrite) ? rd_mux : `CEX_ZERO32;
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign redirect    = redirect_r;
  assign irq_ack     = irq_ack_r;
  assign status_word = status_word_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_reset_vector: assert property (reset_take |=> redirect.valid && redirect.addr == 32'hA000_0000)
    else $error("reset did not redirect to the fixed vector");
  chk_tlb_offset: assert property (gexc_enter && gsel.tlb_vec |=>
    redirect.addr == $past(vector_base_r) + 32'h0000_0400)
    else $error("TLB miss vector wrong");
  chk_gen_offset: assert property (gexc_enter && !gsel.tlb_vec |=>
    redirect.addr == $past(vector_base_r) + 32'h0000_0100)
    else $error("general exception vector wrong");
  chk_irq_offset: assert property (irq_take |=> redirect.addr == $past(vector_base_r) + 32'h0000_0600
    && irq_ack)
    else $error("interrupt vector wrong");
  chk_irq_boundary: assert property (irq_ack |-> $past(instr_done) && !$past(block_bit))
    else $error("interrupt taken off boundary or while blocked");
  chk_saved_state: assert property (entry |=> saved_program_counter_r == $past(cur_pc)
    && saved_status_word_r == $past(status_word_r))
    else $error("saved copies not taken on entry");
  chk_entry_flags: assert property (entry |=> status_word[30:28] == 3'b111)
    else $error("entry flags not set");
  chk_manual_code: assert property (mrst_take |=> exception_event_code_r == 32'h0000_0020)
    else $error("manual reset code wrong");
  chk_blocked_fault: assert property (blocked_fault |=> status_word == 32'h7000_00F0 && !irq_ack)
    else $error("blocked fault did not reset state");
  chk_rte_restore: assert property (rte_take |=> status_word == $past(saved_status_word_r)
    && redirect.addr == $past(saved_program_counter_r))
    else $error("return did not restore state");
  chk_order_first: assert property (gexc_take && gexc_req.fetch_addr_err |=>
    exception_event_code_r[11:0] == 12'h0E0)
    else $error("fetch address error not taken first");
  chk_data_write: assert property (gexc_take && gsel.code == 12'h060 |-> data_write)
    else $error("write TLB code without write access");

  // Power-on code, trap capture, interrupt priority and interrupt codes
  chk_por_code: assert property (por_pend_r |=> exception_event_code_r == `CEX_ZERO32)
    else $error("power-on code wrong");
  chk_trap_capture: assert property (gexc_enter && gsel.code == `CEX_CODE_TRAP |=>
    trap_immediate_r[7:0] == $past(trap_imm))
    else $error("trap immediate not captured");
  chk_irq_priority: assert property (irq_ack |-> !$past(reset_take) && !$past(gsel.hit))
    else $error("interrupt taken over a higher event");
  chk_irq_code: assert property (irq_take |=> interrupt_event_code_r[11:0] == $past(int_code)
    && interrupt_event_code_alt_r[11:0] == $past(int_code))
    else $error("interrupt code not written");

  cov_tlb_entry: cover property (gexc_enter && gsel.tlb_vec ##[1:20] rte_take);
  cov_irq_entry: cover property (irq_take ##1 redirect.valid);
  cov_blocked:   cover property (blocked_fault);
  cov_manual:    cover property (mrst_take);
endmodule

/* tb/cex_pipe_model.sv */
// Pipeline partner model: interrupt source and instruction boundary pacing
`timescale 1ns/1ps
module cex_pipe_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic irq_set,
  input  wire logic stall,
  input  wire logic irq_ack,
  output logic      irq_req,
  output logic      instr_done
);
  // Request is held by the source until the unit acknowledges it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
    end else if (irq_ack) begin
      irq_req <= 1'b0;
    end else if (irq_set) begin
      irq_req <= 1'b1;
    end
  end
  // A long instruction holds off the boundary while stalled
  assign instr_done = !stall;
endmodule

/* tb/tb_cex_entry.sv */
// Self-checking bench for the exception entry unit
`timescale 1ns/1ps
`include "cex_regs.svh"
module tb_cex_entry
  import cex_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic        manual_reset_n = 1, data_write = 0, rte_exec = 0, irq_set = 0, stall = 1, nmi_req = 0;
  logic [31:0] paddr = 0, pwdata = 0, cur_pc = 0, rd, prdata, status_word;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  trap_imm = 8'h5A;
  logic [11:0] irq_code = 12'h200;
  logic        pready, pslverr, irq_ack, irq_req, instr_done;
  cex_gexc_t   gexc_req = '0;
  cex_redir_t  redirect;
  int          num_errors = 0, n_checks = 0, cyc = 0;
  // ---------------------------------------------------------------------------
  // Clock, timeout, instances
  // ---------------------------------------------------------------------------
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  cex_entry dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .manual_reset_n, .cur_pc, .gexc_req, .data_write, .trap_imm, .instr_done, .nmi_req,
    .irq_req, .irq_code, .rte_exec, .redirect, .irq_ack, .status_word);
  cex_pipe_model pipe_u (.pclk, .presetn, .irq_set, .stall, .irq_ack, .irq_req, .instr_done);
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    #1;
    while (pready !== 1'b1 && i < 50) begin
      @(posedge pclk);
      #1;
      i++;
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    {psel, penable} <= 2'b00;
  endtask
  // Waits, bounded, for the one-cycle fetch redirect
  task automatic wait_redir();
    for (int i = 0; i < 40; i++) begin
      #1;
      if (redirect.valid === 1'b1) break;
      @(posedge pclk);
    end
  endtask
  task automatic fault(input logic [11:0] g, input logic dw, input logic [31:0] pc);
    @(posedge pclk);
    {cur_pc, gexc_req, data_write} <= {pc, g, dw};
    @(posedge pclk);
    gexc_req <= '0;
    wait_redir();
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic gexc_case(input logic [11:0] g, input logic dw, input logic [31:0] ofs, input logic [11:0] code);
    apb(1'b1, `CEX_ADDR_STATUS, `CEX_ZERO32);
    fault(g, dw, 32'h0000_1234 + ofs);
    chk("vector", redirect, {1'b1, 32'h1000_0000 + ofs});
    chk("entry_status", status_word[30:28], 3'b111);
    apb(1'b0, `CEX_ADDR_EXC_CODE, `CEX_ZERO32);
    chk("exc_code", rd, {20'h0_0000, code});
    apb(1'b0, `CEX_ADDR_SAVED_PC, `CEX_ZERO32);
    chk("saved_pc", rd, 32'h0000_1234 + ofs);
    apb(1'b0, `CEX_ADDR_SAVED_SR, `CEX_ZERO32);
    chk("saved_sr", rd, `CEX_ZERO32);
  endtask
  task automatic rte_and_block();
    @(posedge pclk);
    rte_exec <= 1'b1;
    @(posedge pclk);
    rte_exec <= 1'b0;
    wait_redir();
    chk("rte_pc", redirect, {1'b1, 32'h0000_1334});
    chk("rte_sr", status_word, `CEX_ZERO32);
    apb(1'b1, `CEX_ADDR_STATUS, 32'h1000_0000);
    fault(12'h002, 1'b1, 32'h0000_2000);
    chk("blocked_vec", redirect, {1'b1, `CEX_RESET_VECTOR});
    chk("blocked_sr", status_word, `CEX_SR_RESET);
  endtask
  task automatic irq_case();
    apb(1'b1, `CEX_ADDR_VEC_BASE, 32'hFFFF_FF00);
    apb(1'b1, `CEX_ADDR_STATUS, `CEX_ZERO32);
    irq_set <= 1'b1;
    @(posedge pclk);
    irq_set <= 1'b0;
    repeat (6) @(posedge pclk);
    #1;
    chk("early_take", {irq_ack, redirect.valid}, 2'b00);
    @(posedge pclk);
    stall <= 1'b0;
    wait_redir();
    chk("irq_vector", redirect, {1'b1, 32'h0000_0500});
    apb(1'b0, `CEX_ADDR_INT_CODE, `CEX_ZERO32);
    chk("int_code", rd, 32'h0000_0200);
    apb(1'b0, `CEX_ADDR_INT_ALT, `CEX_ZERO32);
    chk("int_alt", rd, 32'h0000_0200);
    apb(1'b1, `CEX_ADDR_INT_ALT, 32'h0000_0040);
    chk("alt_write_err", err, 1'b1);
    apb(1'b0, 32'h0000_0010, `CEX_ZERO32);
    chk("unmapped_err", err, 1'b1);
    apb(1'b1, `CEX_ADDR_STATUS, `CEX_ZERO32);
    nmi_req <= 1'b1;
    wait_redir();
    chk("nmi_vector", redirect, {1'b1, 32'h0000_0500});
    @(posedge pclk);
    nmi_req <= 1'b0;
    apb(1'b0, `CEX_ADDR_INT_CODE, `CEX_ZERO32);
    chk("nmi_code", rd, 32'h0000_01C0);
  endtask
  task automatic manual_case();
    @(posedge pclk);
    manual_reset_n <= 1'b0;
    wait_redir();
    chk("manual_vec", redirect, {1'b1, `CEX_RESET_VECTOR});
    @(posedge pclk);
    manual_reset_n <= 1'b1;
    apb(1'b0, `CEX_ADDR_EXC_CODE, `CEX_ZERO32);
    chk("manual_code", rd, 32'h0000_0020);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wait_redir();
    chk("por_vec", redirect, {1'b1, `CEX_RESET_VECTOR});
    apb(1'b0, `CEX_ADDR_EXC_CODE, `CEX_ZERO32);
    chk("por_code", rd, `CEX_ZERO32);
    apb(1'b1, `CEX_ADDR_VEC_BASE, 32'h1000_0000);
    gexc_case(12'h008, 1'b1, 32'h0000_0400, 12'h060);
    gexc_case(12'hC00, 1'b0, 32'h0000_0100, 12'h0E0);
    gexc_case(12'h600, 1'b0, 32'h0000_0400, 12'h040);
    gexc_case(12'h300, 1'b0, 32'h0000_0100, 12'h040);
    gexc_case(12'h0D0, 1'b0, 32'h0000_0100, 12'h180);
    gexc_case(12'h050, 1'b0, 32'h0000_0100, 12'h1A0);
    gexc_case(12'h006, 1'b1, 32'h0000_0100, 12'h060);
    gexc_case(12'h003, 1'b1, 32'h0000_0100, 12'h0C0);
    gexc_case(12'h020, 1'b0, 32'h0000_0100, 12'h160);
    apb(1'b0, `CEX_ADDR_TRAP_IMM, `CEX_ZERO32);
    chk("trap_imm", rd, 32'h0000_005A);
    rte_and_block();
    irq_case();
    manual_case();
    tally_and_finish();
  end
endmodule
